// *** core/adcctl_defs.svh ***
/*
 * adcctl_defs.svh: register offsets, field positions, reset values and
 * timing counts of the converter control block.
 * Assumes inclusion by bare name from design files under core/.
 */
`ifndef ADCCTL_DEFS_SVH
`define ADCCTL_DEFS_SVH

`define ADCCTL_OFS_CONFIG      4'h0
`define ADCCTL_OFS_CLKDIV      4'h4
`define ADCCTL_OFS_IRQ_STATUS  4'h8
`define ADCCTL_OFS_IRQ_ENABLE  4'hC
`define ADCCTL_OFS_IRQ_CLEAR   4'h8
`define ADCCTL_ADDR_W          4

`define ADCCTL_BIT_REF         7
`define ADCCTL_BIT_GO          3
`define ADCCTL_CFG_RST         8'h00
`define ADCCTL_DIV_RST         8'h00
`define ADCCTL_CFG_WMASK       8'hEF

`define ADCCTL_REF_PERIOD_NS   1736
`define ADCCTL_CLK_PERIOD_NS   10
`define ADCCTL_DIV_DEFAULT     8'hAD
`define ADCCTL_CONV_CLOCKS     8'h0E

`define ADCCTL_IRQ_DONE        0

`endif

// *** core/adcctl_pkg.sv ***
/*
 * adcctl_pkg: types of the converter control block.
 * Assumes adcctl_defs.svh holds the numbers.
 */
package adcctl_pkg;

   typedef enum logic [1:0] {
      ADCCTL_JUST_RIGHT  = 2'h0,
      ADCCTL_JUST_SIGNED = 2'h1,
      ADCCTL_JUST_LEFT   = 2'h2,
      ADCCTL_JUST_RSVD   = 2'h3
   } adcctl_just_t;

   typedef struct packed {
      logic         reference_source_select;
      adcctl_just_t result_justify_select;
      logic         reserved;
      logic         convert_go_done;
      logic [2:0]   input_channel_select;
   } adcctl_cfg_t;

   typedef enum logic [1:0] {
      ADCCTL_ST_IDLE  = 2'h0,
      ADCCTL_ST_RUN   = 2'h1,
      ADCCTL_ST_DONE  = 2'h2
   } adcctl_state_t;

   typedef struct packed {
      logic       conv_active;
      logic       ref_external;
      logic [1:0] justify;
      logic [2:0] channel;
      logic       ref_clk;
      logic       start_pulse;
   } adcctl_front_t;

endpackage

// *** core/adcctl_top.sv ***
/*
 * adcctl_top: digital control for an on-chip analog-to-digital converter,
 * with an AXI4-Lite register slave and a conversion-done interrupt.
 * Assumes one clock aclk at 100 MHz, synchronous active-low reset, and a
 * front end that samples on ref_clk edges and reports via conv_ready.
 */
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
// Notes on behaviour
// - reference bit 0 selects analog supply, 1 selects external pin G3
// - justify field: 00 right, 01 signed, 10 left, 11 reserved
// - writing 1 to go/done starts a new conversion unless one is already in progress
// - go/done reads 1 while a conversion is in progress
// - go/done reads 0 once the latest conversion has finished
// - channel field codes 000..111 route port G pins 0..7 to input
// - divider count sets the converter reference clock period
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_defs.svh"

module adcctl_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        clk_en,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        conv_ready,
   output var  logic [7:0]  port_g_analog_en,
   output var  logic        port_g_bit3_ref_in,
   output var  adcctl_pkg::adcctl_front_t front_ff,
   output var  logic        irq
);

   adcctl_pkg::adcctl_cfg_t   cfg_ff;
   logic [7:0]                div_ff;
   logic [7:0]                div_cnt_ff;
   logic [7:0]                conv_cnt_ff;
   adcctl_pkg::adcctl_state_t state_ff;
   logic                      irq_stat_ff;
   logic                      irq_en_ff;
   logic [3:0]                awaddr_ff;
   logic [31:0]               wdata_ff;
   logic [3:0]                wstrb_ff;
   logic                      aw_have_ff;
   logic                      w_have_ff;
   logic                      ref_tick;
   logic                      do_write;
   logic                      go_write;
   logic                      conv_finish;
   logic [31:0]               nxt_rdata;
   logic [1:0]                nxt_rresp;

   function automatic logic addr_hit(input logic [3:0] a,
                                     input logic [3:0] ofs);
      addr_hit = (a[3:2] == ofs[3:2]);
   endfunction

   // one fires on each write response: address and data both held
   assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
   assign go_write = do_write && wstrb_ff[0]
                  && addr_hit(awaddr_ff, `ADCCTL_OFS_CONFIG)
                  && wdata_ff[`ADCCTL_BIT_GO];
   // end at divider period boundary after enough ticks, or early ready
   assign ref_tick = (div_cnt_ff == 8'h00);
   assign conv_finish = (state_ff == adcctl_pkg::ADCCTL_ST_RUN)
                     && (conv_ready
                         || (ref_tick && conv_cnt_ff == 8'h00));

   // write channel capture, accepted in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff    <= 1'b0;
         w_have_ff     <= 1'b0;
         awaddr_ff     <= 4'h0;
         wdata_ff      <= 32'h00000000;
         wstrb_ff      <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end else if (clk_en) begin
         s_axi_awready <= !aw_have_ff && !s_axi_awready;
         s_axi_wready  <= !w_have_ff && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wstrb_ff  <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_hit(awaddr_ff, `ADCCTL_OFS_IRQ_CLEAR)
                            ? 2'h2 : 2'h0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_have_ff   <= 1'b0;
            w_have_ff    <= 1'b0;
         end
      end
   end

   // configuration and divider; status offset doubles as write-only clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_ff    <= `ADCCTL_CFG_RST;
         div_ff    <= `ADCCTL_DIV_DEFAULT;
         irq_en_ff <= 1'b0;
      end else if (clk_en) begin
         if (do_write && wstrb_ff[0]) begin
            if (addr_hit(awaddr_ff, `ADCCTL_OFS_CONFIG)) begin
               // go bit is owned by the sequencer, so a 0 cannot abort
               cfg_ff <= (wdata_ff[7:0] & `ADCCTL_CFG_WMASK
                          & ~(8'h01 << `ADCCTL_BIT_GO))
                       | {4'h0, cfg_ff.convert_go_done | go_write,
                          3'h0};
            end
            if (addr_hit(awaddr_ff, `ADCCTL_OFS_CLKDIV))
               div_ff <= wdata_ff[7:0];
            if (addr_hit(awaddr_ff, `ADCCTL_OFS_IRQ_ENABLE))
               irq_en_ff <= wdata_ff[`ADCCTL_IRQ_DONE];
         end
         if (conv_finish)
            cfg_ff.convert_go_done <= 1'b0;
      end
   end

   // sequencer: reference clock divider and conversion length
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff    <= adcctl_pkg::ADCCTL_ST_IDLE;
         div_cnt_ff  <= 8'h00;
         conv_cnt_ff <= 8'h00;
         front_ff    <= '0;
      end else if (clk_en) begin
         front_ff.start_pulse <= 1'b0;
         div_cnt_ff <= ref_tick ? div_ff : div_cnt_ff - 8'h01;
         if (ref_tick)
            front_ff.ref_clk <= ~front_ff.ref_clk;
         case (state_ff)
            adcctl_pkg::ADCCTL_ST_IDLE,
            adcctl_pkg::ADCCTL_ST_DONE: begin
               if (go_write) begin
                  state_ff    <= adcctl_pkg::ADCCTL_ST_RUN;
                  conv_cnt_ff <= `ADCCTL_CONV_CLOCKS;
                  front_ff.start_pulse <= 1'b1;
                  front_ff.conv_active <= 1'b1;
               end
            end
            adcctl_pkg::ADCCTL_ST_RUN: begin
               if (conv_finish) begin
                  state_ff <= adcctl_pkg::ADCCTL_ST_DONE;
                  front_ff.conv_active <= 1'b0;
               end else if (ref_tick)
                  conv_cnt_ff <= conv_cnt_ff - 8'h01;
            end
            default: state_ff <= adcctl_pkg::ADCCTL_ST_IDLE;
         endcase
         front_ff.ref_external <= cfg_ff.reference_source_select;
         front_ff.justify  <= cfg_ff.result_justify_select;
         front_ff.channel  <= cfg_ff.input_channel_select;
      end
   end

   // pin routing follows config
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_g_analog_en   <= 8'h00;
         port_g_bit3_ref_in <= 1'b0;
      end else if (clk_en) begin
         port_g_analog_en <= 8'h01 << cfg_ff.input_channel_select;
         port_g_bit3_ref_in <= cfg_ff.reference_source_select;
      end
   end

   // interrupt: set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= 1'b0;
         irq         <= 1'b0;
      end else if (clk_en) begin
         if (conv_finish)
            irq_stat_ff <= 1'b1;
         else if (do_write && wstrb_ff[0]
                  && addr_hit(awaddr_ff, `ADCCTL_OFS_IRQ_CLEAR)
                  && wdata_ff[`ADCCTL_IRQ_DONE])
            irq_stat_ff <= 1'b0;
         irq <= irq_stat_ff && irq_en_ff;
      end
   end

   always_comb begin
      nxt_rresp = 2'h0;
      case (s_axi_araddr[3:2])
         2'h0: nxt_rdata = {24'h000000, cfg_ff};
         2'h1: nxt_rdata = {24'h000000, div_ff};
         2'h2: nxt_rdata = {31'h00000000, irq_stat_ff};
         2'h3: nxt_rdata = {31'h00000000, irq_en_ff};
         default: nxt_rdata = 32'h00000000;
      endcase
   end

   // read channel: one cycle arready, data the next
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= 2'h0;
      end else if (clk_en) begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= nxt_rdata;
            s_axi_rresp   <= nxt_rresp;
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   a_go_starts_run: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && go_write && state_ff != adcctl_pkg::ADCCTL_ST_RUN
      |=> state_ff == adcctl_pkg::ADCCTL_ST_RUN && cfg_ff.convert_go_done)
      else $error("go write did not start conversion");
   a_busy_reads_one: assert property (
      @(posedge aclk) disable iff (!aresetn)
      state_ff == adcctl_pkg::ADCCTL_ST_RUN |-> cfg_ff.convert_go_done)
      else $error("go bit low while running");
   a_done_reads_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && conv_finish |=> !cfg_ff.convert_go_done)
      else $error("go bit stuck after finish");
   a_zero_no_abort: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && state_ff == adcctl_pkg::ADCCTL_ST_RUN && !conv_finish
      |=> state_ff == adcctl_pkg::ADCCTL_ST_RUN)
      else $error("conversion aborted");
   a_channel_route: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && $stable(cfg_ff) ##1 clk_en
      |-> port_g_analog_en == (8'h01 << $past(cfg_ff.input_channel_select)))
      else $error("channel routing wrong");
   a_ref_select: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en |=> port_g_bit3_ref_in == $past(cfg_ff.reference_source_select))
      else $error("reference select wrong");
   a_justify_pass: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en |=> front_ff.justify == $past(cfg_ff.result_justify_select))
      else $error("justify not passed");
   a_div_reload: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && ref_tick |=> div_cnt_ff == $past(div_ff))
      else $error("divider did not reload");
   a_cfg_layout: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !cfg_ff.reserved)
      else $error("reserved bit set");
   // a zero written to go while running must leave the busy bit alone
   a_zero_keeps_go: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && do_write && wstrb_ff[0]
      && addr_hit(awaddr_ff, `ADCCTL_OFS_CONFIG)
      && !wdata_ff[`ADCCTL_BIT_GO] && !conv_finish
      |=> cfg_ff.convert_go_done == $past(cfg_ff.convert_go_done))
      else $error("zero write changed go bit");
   a_start_launch: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && go_write && state_ff != adcctl_pkg::ADCCTL_ST_RUN
      |=> front_ff.start_pulse && front_ff.conv_active)
      else $error("front end not started");
   a_active_mirror: assert property (
      @(posedge aclk) disable iff (!aresetn)
      front_ff.conv_active == (state_ff == adcctl_pkg::ADCCTL_ST_RUN))
      else $error("front end activity disagrees with state");
   a_ref_toggle: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && ref_tick |=> front_ff.ref_clk != $past(front_ff.ref_clk))
      else $error("reference clock did not toggle");
   a_tick_count: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && state_ff == adcctl_pkg::ADCCTL_ST_RUN && ref_tick
      && !conv_finish |=> conv_cnt_ff == $past(conv_cnt_ff) - 8'h01)
      else $error("conversion length count skipped");
   // a low enable must hold the sequencer, so the busy bit stays honest
   a_freeze_hold: assert property (
      @(posedge aclk) disable iff (!aresetn)
      !clk_en |=> $stable(state_ff) && $stable(cfg_ff)
      && $stable(div_cnt_ff))
      else $error("state moved while clock enable low");
   a_done_flags: assert property (
      @(posedge aclk) disable iff (!aresetn)
      clk_en && conv_finish |=> irq_stat_ff)
      else $error("finish did not set status");

endmodule

`default_nettype wire

// *** testbench/adcctl_front_model.sv ***
/*
 * adcctl_front_model: behavioural analog front end that answers a started
 * conversion with conv_ready after a chosen number of cycles.
 * Assumes front comes straight from adcctl_top; a delay of 0 never answers.
 */
`timescale 1ns/1ps
`default_nettype none

module adcctl_front_model (
   input  wire logic                    aclk,
   input  wire logic                    aresetn,
   input  wire adcctl_pkg::adcctl_front_t front,
   input  wire logic [7:0]              ready_delay,
   output var  logic                    conv_ready
);
   logic [7:0] cnt_ff;

   // ready is a level that only means something while a conversion runs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 8'h00;
         conv_ready <= 1'b0;
      end else if (front.start_pulse) begin
         cnt_ff <= ready_delay;
         conv_ready <= 1'b0;
      end else if (!front.conv_active) begin
         conv_ready <= 1'b0;
      end else if (cnt_ff == 8'h01) begin
         conv_ready <= 1'b1;
      end else if (cnt_ff > 8'h01) begin
         cnt_ff <= cnt_ff - 8'h01;
      end
   end
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
/*
 * testbench: self-checking bench of adcctl_top over AXI4-Lite.
 * Assumes adcctl_front_model stands in for the analog front end.
 */
`timescale 1ns/1ps
`default_nettype none
`include "adcctl_defs.svh"
`define CHK(nm,e,g) begin checks_done++; if ((g) !== (e)) begin errors++; \
$display("BAD %s exp %0h got %0h", nm, e, g); end end

module testbench;
   logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awready, wready, bvalid, arready, rvalid, conv_ready, ref_pin, irq;
   logic [1:0] bresp, rresp, r;
   logic [7:0] an_en, dly = 8'h00;
   adcctl_pkg::adcctl_front_t front;
   int errors = 0, checks_done = 0, starts = 0;
   time t0;
   logic [7:0] rows [8] = '{8'h00, 8'hA1, 8'hC2, 8'h13,
                            8'h84, 8'hA5, 8'h46, 8'hD7};

   always #5 aclk = ~aclk;
   always @(posedge aclk) if (front.start_pulse === 1'b1) starts++;

   adcctl_top i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_ready(conv_ready),
      .port_g_analog_en(an_en), .port_g_bit3_ref_in(ref_pin),
      .front_ff(front), .irq(irq));

   adcctl_front_model i_front (.aclk(aclk), .aresetn(aresetn), .front(front),
      .ready_delay(dly), .conv_ready(conv_ready));

   task automatic axw(input logic [3:0] a, input logic [31:0] v,
                      output logic [1:0] resp);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            done = 1'b1;
            resp = bresp;
            bready <= 1'b0;
         end
      end
   endtask

   task automatic axr(input logic [3:0] a, output logic [31:0] v);
      bit done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            done = 1'b1;
            v = rdata;
            rready <= 1'b0;
         end
      end
   endtask

   task automatic wrap_up();
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // a hung handshake ends up here rather than running forever
   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      wrap_up();
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("cfg_rst", 32'h0, d)
      axr(`ADCCTL_OFS_CLKDIV, d);
      `CHK("div_rst", 32'hAD, d)
      `CHK("irq_rst", 1'b0, irq)
      // bit 4 is written high in two rows and must read back low
      for (int i = 0; i < 8; i++) begin
         axw(`ADCCTL_OFS_CONFIG, {24'h0, rows[i]}, r);
         `CHK("bresp", 2'h0, r)
         axr(`ADCCTL_OFS_CONFIG, d);
         `CHK("config", {24'h0, rows[i] & 8'hEF}, d)
         `CHK("pin_route", 8'h01 << rows[i][2:0], an_en)
         `CHK("ref_pin", rows[i][7], ref_pin)
         `CHK("ref_ext", rows[i][7], front.ref_external)
         `CHK("justify", rows[i][6:5], front.justify)
         `CHK("channel", rows[i][2:0], front.channel)
      end
      axw(`ADCCTL_OFS_CLKDIV, 32'h3, r);
      axr(`ADCCTL_OFS_CLKDIV, d);
      `CHK("div", 32'h3, d)
      `CHK("rresp", 2'h0, rresp)
      // only byte lane 0 carries the divider
      wstrb <= 4'hE;
      axw(`ADCCTL_OFS_CLKDIV, 32'h7, r);
      wstrb <= 4'hF;
      axr(`ADCCTL_OFS_CLKDIV, d);
      `CHK("div_lane", 32'h3, d)
      axw(`ADCCTL_OFS_IRQ_ENABLE, 32'h1, r);
      // slow front end: the conversion runs its full 15 ticks
      axw(`ADCCTL_OFS_CONFIG, 32'h0D, r);
      @(posedge front.ref_clk);
      t0 = $time;
      @(posedge front.ref_clk);
      `CHK("ref_period", 64'd80, $time - t0)
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("go_busy", 32'h0D, d)
      `CHK("starts", 1, starts)
      axw(`ADCCTL_OFS_CONFIG, 32'h05, r);
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("go_kept", 32'h0D, d)
      `CHK("no_start", 1, starts)
      repeat (100) @(posedge aclk);
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("go_done", 32'h05, d)
      `CHK("irq_on", 1'b1, irq)
      axw(`ADCCTL_OFS_IRQ_STATUS, 32'h1, r);
      `CHK("clr_resp", 2'h2, r)
      repeat (2) @(posedge aclk);
      `CHK("irq_off", 1'b0, irq)
      // prompt front end with the interrupt masked
      dly <= 8'h05;
      axw(`ADCCTL_OFS_IRQ_ENABLE, 32'h0, r);
      axw(`ADCCTL_OFS_CONFIG, 32'h08, r);
      repeat (20) @(posedge aclk);
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("go_early", 32'h00, d)
      `CHK("irq_mask", 1'b0, irq)
      axr(`ADCCTL_OFS_IRQ_STATUS, d);
      `CHK("status", 32'h1, d)
      // a low enable stretches a slow conversion well past its length
      dly <= 8'h00;
      axw(`ADCCTL_OFS_CONFIG, 32'h0A, r);
      clk_en <= 1'b0;
      repeat (200) @(posedge aclk);
      clk_en <= 1'b1;
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("go_frozen", 32'h0A, d)
      `CHK("active", 1'b1, front.conv_active)
      repeat (100) @(posedge aclk);
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("go_thawed", 32'h02, d)
      `CHK("idle", 1'b0, front.conv_active)
      // second reset in mid-run
      axw(`ADCCTL_OFS_CONFIG, 32'h8B, r);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axr(`ADCCTL_OFS_CONFIG, d);
      `CHK("cfg_rst2", 32'h0, d)
      `CHK("active_rst", 1'b0, front.conv_active)
      axr(`ADCCTL_OFS_CLKDIV, d);
      `CHK("div_rst2", 32'hAD, d)
      wrap_up();
   end
endmodule

`default_nettype wire
